// >>> rtl/rtc_cal_pkg.sv
`default_nettype none
package rtc_cal_pkg;

    // Register indices; the byte address on APB is four times the index; the ADDR_ values are byte addresses
    localparam logic [7:0] IDX_SCRATCH = 8'h03;
    localparam logic [7:0] IDX_SECONDS = 8'h04;
    localparam logic [7:0] IDX_MINUTES = 8'h05;
    localparam logic [7:0] IDX_HOURS = 8'h06;
    localparam logic [7:0] IDX_DAYS = 8'h07;
    localparam logic [7:0] IDX_WDAYS = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h40;
    localparam logic [7:0] ADDR_CTX = 8'h44;
    localparam logic [7:0] ADDR_STAT = 8'h48;
    localparam logic [7:0] ADDR_MASK = 8'h4c;

    // Field positions
    localparam int CTRL_FMT12_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam int OSF_BIT = 7;
    localparam int PM_BIT = 5;
    localparam int ST_TICK_BIT = 0;
    localparam int ST_MIN_BIT = 1;
    localparam int ST_OSC_BIT = 2;
    localparam int ST_DAY_BIT = 3;
    localparam int STAT_W = 4;

    // Reset values
    localparam logic [7:0] SCRATCH_RST = 8'h00;
    localparam logic OSF_RST = 1'b1;
    localparam logic [6:0] SEC_RST = 7'h00;
    localparam logic [6:0] MIN_RST = 7'h00;
    localparam logic [5:0] HOUR_RST = 6'h00;
    localparam logic [5:0] DAY_RST = 6'h01;
    localparam logic [2:0] WDAY_RST = 3'h6;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [12:0] CTX_RST = 13'h0100;
    localparam logic [3:0] STAT_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;

    // Counter limits
    localparam logic [6:0] SEC_LAST = 7'h59;
    localparam logic [6:0] MIN_LAST = 7'h59;
    localparam logic [5:0] HOUR24_LAST = 6'h23;
    localparam logic [2:0] WDAY_LAST = 3'h6;

    typedef struct packed {
        logic osf;
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [5:0] day;
        logic [2:0] wday;
    } time_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } bus_state_t;

endpackage : rtc_cal_pkg
`default_nettype wire

// >>> rtl/rtc_time_calendar_regs.sv
`default_nettype none
// How it works
// - A scratch byte at index 03h keeps what software writes; resets to 0.
// - Seconds at 04h: BCD tens in 6..4, units in 3..0, stop flag in bit 7.
// - The stop flag is set while the oscillator is stopped; it resets to 1.
// - Until resonance is reported stable the oscillator counts as stopped.
// - The flag stays set until software writes 0 to it while running.
// - Minutes at 05h: BCD tens in 6..4, units in 3..0, bit 7 reads 0.
// - 12-hour hours at 06h: meridiem in bit 5, tens in 4, units in 3..0.
// - 24-hour hours: BCD tens 0..2 in bits 5..4 and units in bits 3..0.
// - The format select bit of the control register picks 12 or 24 hours.
// - Days at 07h: BCD tens in 5..4, units in 3..0, reset value 1.
// - A year divisible by four, 00 included, gives February a 29th day.
// - Weekdays at 08h: a count 0..6 in bits 2..0, bits 7..3 read 0.
// - The weekday resets to 6 and counts 0 to 6 cyclically.
// - While a host access is in progress the time counters stand still.
// - One tick that arrives while blocked is stored and applied after.
module rtc_time_calendar_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic tick_pin,
    input wire logic osc_ok_pin,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic month_carry
);

    rtc_cal_pkg::time_t t_q;
    rtc_cal_pkg::time_t t_inc;
    rtc_cal_pkg::bus_state_t bus_q;
    logic [7:0] scratch_q;
    logic [1:0] ctrl_q;
    logic [12:0] ctx_q;
    logic [3:0] stat_q;
    logic [3:0] stat_d;
    logic [3:0] mask_q;
    logic [2:0] sync_q [0:1];
    logic [1:0] filt_q;
    logic tick_prev_q;
    logic pend_q;
    logic [31:0] rd_d;
    logic err_d;
    logic [1:0] pins;
    logic tick_ev;
    logic osc_stopped;
    logic blocked;
    logic advance;
    logic access;
    logic complete;
    logic wr_b0;
    logic wr_b1;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic day_wrap;
    logic leap;
    logic [7:0] day_max;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction : bcd_inc

    // Pin inputs: three-stage synchroniser, a change counts once the
    // last two stages agree
    assign pins = {osc_ok_pin, tick_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_q[gi] <= 3'h0;
                    filt_q[gi] <= 1'b0;
                end else begin
                    sync_q[gi] <= {sync_q[gi][1:0], pins[gi]};
                    if (sync_q[gi][1] == sync_q[gi][2]) begin
                        filt_q[gi] <= sync_q[gi][2];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_prev_q <= 1'b0;
        end else begin
            tick_prev_q <= filt_q[0];
        end
    end

    assign tick_ev = filt_q[0] & ~tick_prev_q;
    // Oscillator counts as stopped until its good level has been seen
    assign osc_stopped = ~filt_q[1];

    // APB slave: one wait state, answer registered
    assign access = psel & penable & (bus_q == rtc_cal_pkg::BUS_IDLE);
    assign complete = psel & penable & pready;
    assign wr_b0 = complete & pwrite & pstrb[0];
    assign wr_b1 = complete & pwrite & pstrb[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_q <= rtc_cal_pkg::BUS_IDLE;
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            case (bus_q)
                rtc_cal_pkg::BUS_IDLE: begin
                    if (access) begin
                        bus_q <= rtc_cal_pkg::BUS_RESP;
                        pready <= 1'b1;
                        prdata <= pwrite ? 32'h0 : rd_d;
                        pslverr <= err_d;
                    end
                end
                default: begin
                    bus_q <= rtc_cal_pkg::BUS_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // Read decode; unused upper bits read zero
    always_comb begin
        rd_d = 32'h0;
        err_d = 1'b0;
        if (paddr == {rtc_cal_pkg::IDX_SCRATCH[5:0], 2'b00}) begin
            rd_d = {24'h0, scratch_q};
        end else if (paddr == {rtc_cal_pkg::IDX_SECONDS[5:0], 2'b00}) begin
            rd_d = {24'h0, t_q.osf, t_q.sec};
        end else if (paddr == {rtc_cal_pkg::IDX_MINUTES[5:0], 2'b00}) begin
            rd_d = {25'h0, t_q.min};
        end else if (paddr == {rtc_cal_pkg::IDX_HOURS[5:0], 2'b00}) begin
            rd_d = {26'h0, t_q.hour};
        end else if (paddr == {rtc_cal_pkg::IDX_DAYS[5:0], 2'b00}) begin
            rd_d = {26'h0, t_q.day};
        end else if (paddr == {rtc_cal_pkg::IDX_WDAYS[5:0], 2'b00}) begin
            rd_d = {29'h0, t_q.wday};
        end else if (paddr == rtc_cal_pkg::ADDR_CTRL) begin
            rd_d = {30'h0, ctrl_q};
        end else if (paddr == rtc_cal_pkg::ADDR_CTX) begin
            rd_d = {19'h0, ctx_q};
        end else if (paddr == rtc_cal_pkg::ADDR_STAT) begin
            rd_d = {28'h0, stat_q};
        end else if (paddr == rtc_cal_pkg::ADDR_MASK) begin
            rd_d = {28'h0, mask_q};
        end else begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scratch_q <= rtc_cal_pkg::SCRATCH_RST;
        end else if (wr_b0 && !pslverr &&
                     paddr == {rtc_cal_pkg::IDX_SCRATCH[5:0], 2'b00}) begin
            scratch_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= rtc_cal_pkg::CTRL_RST;
            mask_q <= rtc_cal_pkg::MASK_RST;
            ctx_q <= rtc_cal_pkg::CTX_RST;
        end else begin
            if (wr_b0 && paddr == rtc_cal_pkg::ADDR_CTRL) begin
                ctrl_q <= pwdata[1:0];
            end
            if (wr_b0 && paddr == rtc_cal_pkg::ADDR_MASK) begin
                mask_q <= pwdata[3:0];
            end
            if (wr_b0 && paddr == rtc_cal_pkg::ADDR_CTX) begin
                ctx_q[7:0] <= pwdata[7:0];
            end
            if (wr_b1 && paddr == rtc_cal_pkg::ADDR_CTX) begin
                ctx_q[12:8] <= pwdata[12:8];
            end
        end
    end

    // Time counters are frozen during a bus access or a software hold
    assign blocked = psel | ctrl_q[rtc_cal_pkg::CTRL_HOLD_BIT];
    assign advance = ~blocked & (tick_ev | pend_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else if (blocked) begin
            pend_q <= pend_q | tick_ev;
        end else begin
            pend_q <= pend_q & tick_ev;
        end
    end

    // Leap year when the BCD year is divisible by four
    always_comb begin
        if (ctx_q[4]) begin
            leap = (ctx_q[3:0] == 4'h2) || (ctx_q[3:0] == 4'h6);
        end else begin
            leap = (ctx_q[3:0] == 4'h0) || (ctx_q[3:0] == 4'h4) ||
                   (ctx_q[3:0] == 4'h8);
        end
        if (ctx_q[12:8] == 5'h02) begin
            day_max = leap ? 8'h29 : 8'h28;
        end else if (ctx_q[12:8] == 5'h04 || ctx_q[12:8] == 5'h06 ||
                     ctx_q[12:8] == 5'h09 || ctx_q[12:8] == 5'h11) begin
            day_max = 8'h30;
        end else begin
            day_max = 8'h31;
        end
    end

    // Next time value for one tick
    always_comb begin
        logic [7:0] s8;
        logic [7:0] m8;
        logic [7:0] h8;
        logic [7:0] d8;
        s8 = bcd_inc({1'b0, t_q.sec});
        m8 = bcd_inc({1'b0, t_q.min});
        h8 = bcd_inc({3'b000, t_q.hour[4:0]});
        d8 = bcd_inc({2'b00, t_q.day});
        t_inc = t_q;
        sec_wrap = (t_q.sec == rtc_cal_pkg::SEC_LAST);
        min_wrap = sec_wrap && (t_q.min == rtc_cal_pkg::MIN_LAST);
        hour_wrap = 1'b0;
        t_inc.sec = sec_wrap ? 7'h00 : s8[6:0];
        if (sec_wrap) begin
            t_inc.min = (t_q.min == rtc_cal_pkg::MIN_LAST) ? 7'h00 : m8[6:0];
        end
        if (min_wrap) begin
            if (ctrl_q[rtc_cal_pkg::CTRL_FMT12_BIT]) begin
                if (t_q.hour[4:0] == 5'h12) begin
                    t_inc.hour = {t_q.hour[5], 5'h01};
                end else if (t_q.hour[4:0] == 5'h11) begin
                    t_inc.hour = {~t_q.hour[rtc_cal_pkg::PM_BIT], 5'h12};
                    hour_wrap = t_q.hour[rtc_cal_pkg::PM_BIT];
                end else begin
                    t_inc.hour = {t_q.hour[5], h8[4:0]};
                end
            end else if (t_q.hour == rtc_cal_pkg::HOUR24_LAST) begin
                t_inc.hour = 6'h00;
                hour_wrap = 1'b1;
            end else begin
                t_inc.hour = {h8[5:0]} | {t_q.hour[5] & ~h8[4], 5'h00};
            end
        end
        day_wrap = hour_wrap && ({2'b00, t_q.day} >= day_max);
        if (hour_wrap) begin
            t_inc.day = day_wrap ? 6'h01 : d8[5:0];
            t_inc.wday = (t_q.wday == rtc_cal_pkg::WDAY_LAST) ?
                         3'h0 : t_q.wday + 3'h1;
        end
    end

    // Counters; writes only happen with psel high, so never with advance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_q.sec <= rtc_cal_pkg::SEC_RST;
            t_q.min <= rtc_cal_pkg::MIN_RST;
            t_q.hour <= rtc_cal_pkg::HOUR_RST;
            t_q.day <= rtc_cal_pkg::DAY_RST;
            t_q.wday <= rtc_cal_pkg::WDAY_RST;
        end else if (advance) begin
            t_q.sec <= t_inc.sec;
            t_q.min <= t_inc.min;
            t_q.hour <= t_inc.hour;
            t_q.day <= t_inc.day;
            t_q.wday <= t_inc.wday;
        end else if (wr_b0) begin
            if (paddr == {rtc_cal_pkg::IDX_SECONDS[5:0], 2'b00}) begin
                t_q.sec <= pwdata[6:0];
            end
            if (paddr == {rtc_cal_pkg::IDX_MINUTES[5:0], 2'b00}) begin
                t_q.min <= pwdata[6:0];
            end
            if (paddr == {rtc_cal_pkg::IDX_HOURS[5:0], 2'b00}) begin
                t_q.hour <= pwdata[5:0];
            end
            if (paddr == {rtc_cal_pkg::IDX_DAYS[5:0], 2'b00}) begin
                t_q.day <= pwdata[5:0];
            end
            if (paddr == {rtc_cal_pkg::IDX_WDAYS[5:0], 2'b00}) begin
                t_q.wday <= pwdata[2:0];
            end
        end
    end

    // Stop flag: a stopped oscillator wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_q.osf <= rtc_cal_pkg::OSF_RST;
        end else if (osc_stopped) begin
            t_q.osf <= 1'b1;
        end else if (wr_b0 &&
                     paddr == {rtc_cal_pkg::IDX_SECONDS[5:0], 2'b00}) begin
            t_q.osf <= pwdata[rtc_cal_pkg::OSF_BIT];
        end
    end

    // Sticky event status, cleared by reading it; a new event wins
    always_comb begin
        stat_d = stat_q;
        if (complete && !pwrite && paddr == rtc_cal_pkg::ADDR_STAT) begin
            stat_d = 4'h0;
        end
        stat_d[rtc_cal_pkg::ST_TICK_BIT] |= advance;
        stat_d[rtc_cal_pkg::ST_MIN_BIT] |= advance & sec_wrap;
        stat_d[rtc_cal_pkg::ST_OSC_BIT] |= osc_stopped;
        stat_d[rtc_cal_pkg::ST_DAY_BIT] |= advance & day_wrap;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= rtc_cal_pkg::STAT_RST;
            irq <= 1'b0;
            month_carry <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq <= |(stat_d & mask_q);
            month_carry <= advance & day_wrap;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence wr_sec_s;
        wr_b0 && paddr == {rtc_cal_pkg::IDX_SECONDS[5:0], 2'b00};
    endsequence

    sequence last_second_s;
        advance && min_wrap;
    endsequence

    scratch_store_a: assert property (
        wr_b0 && paddr == {rtc_cal_pkg::IDX_SCRATCH[5:0], 2'b00}
        |=> scratch_q == $past(pwdata[7:0]))
        else $error("scratch byte did not store write data");
    sec_wrap_a: assert property (
        advance && t_q.sec == 7'h59 |=> t_q.sec == 7'h00)
        else $error("seconds did not wrap after 59");
    osc_set_a: assert property (
        osc_stopped |=> t_q.osf)
        else $error("stop flag not set while oscillator stopped");
    osc_sticky_a: assert property (
        t_q.osf &&
        !(wr_b0 && paddr == {rtc_cal_pkg::IDX_SECONDS[5:0], 2'b00})
        |=> t_q.osf)
        else $error("stop flag cleared without a write");
    osc_clear_a: assert property (
        wr_sec_s ##0 (!pwdata[7] && !osc_stopped) |=> !t_q.osf)
        else $error("stop flag clear ignored");
    min_read_a: assert property (
        access && !pwrite &&
        paddr == {rtc_cal_pkg::IDX_MINUTES[5:0], 2'b00}
        |=> pready && prdata[31:7] == 25'h0)
        else $error("minutes read shows upper bits");
    hour12_wrap_a: assert property (
        last_second_s ##0 (ctrl_q[0] && t_q.hour[4:0] == 5'h12)
        |=> t_q.hour[4:0] == 5'h01 && $stable(t_q.hour[5]))
        else $error("12-hour wrap 12 to 01 broken");
    hour24_wrap_a: assert property (
        last_second_s ##0 (!ctrl_q[0] && t_q.hour == 6'h23)
        |=> t_q.hour == 6'h00 && t_q.min == 7'h00)
        else $error("24-hour wrap broken");
    leap_feb_a: assert property (
        last_second_s ##0 (hour_wrap && t_q.day == 6'h28 &&
        ctx_q[12:8] == 5'h02 && leap) |=> t_q.day == 6'h29)
        else $error("leap February lost its 29th");
    wday_wrap_a: assert property (
        advance && hour_wrap && t_q.wday == 3'h6 |=> t_q.wday == 3'h0)
        else $error("weekday did not wrap after 6");
    hold_still_a: assert property (
        blocked |=> $stable(t_q.sec) && $stable(t_q.min) &&
        $stable(t_q.day) || $past(wr_b0))
        else $error("time advanced during an access");
    pend_apply_a: assert property (
        pend_q && !blocked && !tick_ev
        |-> advance ##1 !pend_q)
        else $error("stored tick not applied after access");

endmodule : rtc_time_calendar_regs
`default_nettype wire

// >>> dv/xtal_model.sv
`default_nettype none
module xtal_model (
    input wire logic pclk,
    output logic tick_pin,
    output logic osc_ok_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Resonance is not yet stable at power-on
    initial begin
        tick_pin = 1'b0;
        osc_ok_pin = 1'b0;
    end
    // One divider tick, each level held long enough for the filter
    task automatic pulse();
        tick_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        tick_pin <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask : pulse
    // Start or stop the crystal
    task automatic run(input logic on);
        osc_ok_pin <= on;
        repeat (6) @(posedge pclk);
    endtask : run
endmodule : xtal_model
`default_nettype wire

// >>> dv/rtc_time_calendar_regs_test.sv
`default_nettype none
module rtc_time_calendar_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_RAM = rtc_cal_pkg::IDX_SCRATCH << 2;
    localparam logic [7:0] A_SEC = rtc_cal_pkg::IDX_SECONDS << 2;
    localparam logic [7:0] A_MIN = rtc_cal_pkg::IDX_MINUTES << 2;
    localparam logic [7:0] A_HR = rtc_cal_pkg::IDX_HOURS << 2;
    localparam logic [7:0] A_DAY = rtc_cal_pkg::IDX_DAYS << 2;
    localparam logic [7:0] A_WD = rtc_cal_pkg::IDX_WDAYS << 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic tick_pin, osc_ok_pin, month_carry, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    int mismatches, n_checks, cycles, carries;

    rtc_time_calendar_regs i_rtc_time_calendar_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3),
        .tick_pin(tick_pin), .osc_ok_pin(osc_ok_pin), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .month_carry(month_carry)
    );
    xtal_model i_xtal_model (
        .pclk(pclk), .tick_pin(tick_pin), .osc_ok_pin(osc_ok_pin)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (month_carry === 1'b1) carries++;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        chk(32'(n), 32'h2);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd

    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : chk_irq

    task automatic reset_and_map();
        rd(A_RAM, 32'h00);
        rd(A_SEC, 32'h80);
        rd(A_MIN, 32'h00);
        rd(A_HR, 32'h00);
        rd(A_DAY, 32'h01);
        rd(A_WD, 32'h06);
        wr(A_RAM, 32'ha5);
        rd(A_RAM, 32'ha5);
        rd(8'h30, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        wr(A_MIN, 32'hff);
        rd(A_MIN, 32'h7f);
        wr(A_HR, 32'hff);
        rd(A_HR, 32'h3f);
        wr(A_DAY, 32'hff);
        rd(A_DAY, 32'h3f);
        wr(A_WD, 32'hff);
        rd(A_WD, 32'h07);
    endtask : reset_and_map

    task automatic osc_flag();
        wr(A_SEC, 32'h00);
        rd(A_SEC, 32'h80);
        i_xtal_model.run(1'b1);
        wr(A_SEC, 32'h00);
        rd(A_SEC, 32'h00);
        i_xtal_model.run(1'b0);
        i_xtal_model.run(1'b1);
        rd(A_SEC, 32'h80);
        wr(A_SEC, 32'h00);
        rd(A_SEC, 32'h00);
    endtask : osc_flag

    task automatic roll(input logic [31:0] ctx, input logic [31:0] day,
                        input logic [31:0] eday, input int ec);
        int c0;
        wr(rtc_cal_pkg::ADDR_CTX, ctx);
        wr(A_SEC, 32'h59);
        wr(A_MIN, 32'h59);
        wr(A_HR, 32'h23);
        wr(A_DAY, day);
        wr(A_WD, 32'h06);
        c0 = carries;
        i_xtal_model.pulse();
        rd(A_SEC, 32'h00);
        rd(A_MIN, 32'h00);
        rd(A_HR, 32'h00);
        rd(A_DAY, eday);
        rd(A_WD, 32'h00);
        chk(32'(carries - c0), ec);
    endtask : roll

    task automatic twelve_hour();
        wr(rtc_cal_pkg::ADDR_CTRL, 32'h1);
        wr(A_SEC, 32'h59);
        wr(A_MIN, 32'h59);
        wr(A_HR, 32'h11);
        i_xtal_model.pulse();
        rd(A_HR, 32'h32);
        wr(A_SEC, 32'h59);
        wr(A_MIN, 32'h59);
        i_xtal_model.pulse();
        rd(A_HR, 32'h21);
        wr(rtc_cal_pkg::ADDR_CTRL, 32'h0);
    endtask : twelve_hour

    task automatic hold_ticks();
        wr(A_SEC, 32'h10);
        wr(rtc_cal_pkg::ADDR_CTRL, 32'h2);
        i_xtal_model.pulse();
        i_xtal_model.pulse();
        rd(A_SEC, 32'h10);
        wr(rtc_cal_pkg::ADDR_CTRL, 32'h0);
        rd(A_SEC, 32'h11);
    endtask : hold_ticks

    task automatic irq_test();
        apb(1'b0, rtc_cal_pkg::ADDR_STAT, 32'h0);
        wr(rtc_cal_pkg::ADDR_MASK, 32'h1);
        wr(A_SEC, 32'h05);
        i_xtal_model.pulse();
        chk_irq(1'b1);
        rd(rtc_cal_pkg::ADDR_STAT, 32'h1);
        chk_irq(1'b0);
        wr(rtc_cal_pkg::ADDR_MASK, 32'h0);
        i_xtal_model.pulse();
        chk_irq(1'b0);
        rd(A_SEC, 32'h07);
    endtask : irq_test

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reset_and_map();
        osc_flag();
        roll(32'h0200, 32'h28, 32'h29, 0);
        roll(32'h0200, 32'h29, 32'h01, 1);
        roll(32'h0201, 32'h28, 32'h01, 1);
        roll(32'h0204, 32'h28, 32'h29, 0);
        twelve_hour();
        hold_ticks();
        irq_test();
        end_of_test();
    end
endmodule : rtc_time_calendar_regs_test
`default_nettype wire
